/* rtl/chgsv_pkg.sv */
/*
 Shared constants and types of the charger supervisor.
 Assumes a 125 MHz system clock and comparator levels from the analog side.
*/
package chgsv_pkg;
   localparam logic [3:0] CHGSV_GROUP_ID       = 4'h9;
   localparam logic [7:0] CHGSV_STATUS_OFS     = 8'h00;
   localparam logic [7:0] CHGSV_CFG1_OFS       = 8'h02;
   localparam logic [7:0] CHGSV_CFG4_OFS       = 8'h05;
   localparam logic [7:0] CHGSV_UNLOCK_OFS     = 8'h11;
   localparam logic [7:0] CHGSV_NVCTRL_OFS     = 8'h12;
   localparam logic [7:0] CHGSV_STATUS_RST     = 8'h00;
   localparam logic [7:0] CHGSV_CFG_RST        = 8'h00;
   localparam int         CHGSV_BIT_OV         = 7;
   localparam int         CHGSV_BIT_FCTO       = 6;
   localparam int         CHGSV_BIT_COLD       = 5;
   localparam int         CHGSV_BIT_HOT        = 4;
   localparam int         CHGSV_BIT_TSD        = 3;
   localparam int         CHGSV_BIT_TOPTO      = 2;
   localparam int         CHGSV_BIT_UV         = 1;
   localparam int         CHGSV_BIT_OPEN       = 0;
   localparam logic [7:0] CHGSV_FAULT_MASK     = 8'hf0;

   typedef enum logic [4:0] {
      CHGSV_INIT = 5'b00001,
      CHGSV_PRE  = 5'b00010,
      CHGSV_FULL = 5'b00100,
      CHGSV_CV   = 5'b01000,
      CHGSV_DONE = 5'b10000
   } chgsv_state_t;

   typedef enum logic [5:0] {
      CHGSV_I_IDLE = 6'b000001,
      CHGSV_I_ADDR = 6'b000010,
      CHGSV_I_AACK = 6'b000100,
      CHGSV_I_RX   = 6'b001000,
      CHGSV_I_TX   = 6'b010000,
      CHGSV_I_DACK = 6'b100000
   } chgsv_i2c_t;

   // Comparator levels from the analog front end
   typedef struct packed {
      logic batt_above_pre;
      logic batt_over;
      logic src_over_limit;
      logic cur_below_eoc;
      logic cur_below_topend;
      logic in_cv;
      logic cycle_current_limit;
      logic junction_hot;
      logic junction_cool;
      logic supply_rise;
      logic supply_fall;
      logic full_charge_timeout;
      logic topoff_timeout;
      logic therm_open;
      logic [5:0] therm_zone;
   } chgsv_sense_t;
endpackage : chgsv_pkg

/* rtl/chgsv_top.sv */
/*
 Charger supervisor: charge sequencer, protection, status register and I2C slave.
 Assumes sense inputs and SCL/SDA are asynchronous; SDA wire resolved outside.
*/
`timescale 1ns/1ps
// How it works
// - Stay in pre-charge below the pre-charge threshold, then go to full charge
// - In full charge the rated-current limit overrides power tracking when exceeded
// - In constant-voltage regulation, charge current decides when charging is done
// - Voltage and current settings are picked per one of three temperature bands
// - Stop outside 0 and 60 degrees, resume after ten degrees of return
// - Intermediate band boundaries use one degree of hysteresis
// - Run only with enable high and supply risen; stop when supply falls low
// - Over-current comparator ends the switching cycle early while enabled
// - Junction over-temperature tri-states switch node until cool, repeating
// - Battery over-voltage shuts down the charge profile as a fault
// - Over-voltage, temperature range or full-charge timeout stop and pull fault low
// - Fault gone returns to initialize; fault output held until status read
// - Warnings stop charging, set status bit, no fault output, hold initialize
// - Status read clears bits whose cause is gone; fault output released once faults cleared
// - I2C slave for standard and fast mode with auto-increment
// - Address is fixed group 1001 plus three select bits
// - Write carries pointer byte then data bytes, each acknowledged
// - Master starts with START, address MSB first, read is one
// - Device acknowledges address and each received byte in ninth clock
// - On master not-acknowledge the device releases SDA
// - SDA change while SCL high is START (fall) or STOP (rise)
// - Configuration and control registers only accessible after unlock bit set
// - Status register is read-only with eight flags, over-voltage on top
module chgsv_top
   import chgsv_pkg::*;
(
   // Clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_b_in,
   // Pins
   input  wire logic         enable_in,
   input  wire logic [2:0]   addr_select_in,
   input  wire chgsv_sense_t sense_in,
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe_out,
   output logic              fault_out_n_out,
   output logic              fault_oe_out,
   // Regulator controls
   output logic              switch_node_oe_out,
   output logic              cycle_end_out,
   output logic              precharge_out,
   output logic              current_limit_sel_out,
   output logic [2:0]        vterm_code_out,
   output logic [3:0]        icharge_code_out,
   output logic [1:0]        pre_code_out
);
   // Sync of all asynchronous inputs
   localparam int NS = $bits(chgsv_sense_t) + 6;
   // Bus lines rest high so no false edge follows reset
   localparam logic [NS-1:0] SYNC_RST = {{(NS-2){1'b0}}, 2'b11};
   logic [NS-1:0] s1_reg, s2_reg;
   logic [NS-1:0] raw;
   assign raw = {enable_in, addr_select_in, sense_in, scl_in, sda_in};
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
      if (!rst_b_in)
      begin
         s1_reg <= SYNC_RST;
         s2_reg <= SYNC_RST;
      end
      else
      begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
      end
   chgsv_sense_t sn;
   logic en_s, scl_s, sda_s;
   logic [2:0] asel;
   assign {en_s, asel, sn, scl_s, sda_s} = s2_reg;

   // I2C edge/condition detect
   logic scl_d_reg, sda_d_reg;
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
      if (!rst_b_in)
      begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // Register storage: config 02..05, unlock, nv control
   logic [7:0] cfg_reg [4];
   logic [7:0] cfg_next [4];
   logic       unlock_reg, unlock_next;
   logic [7:0] nvctl_reg, nvctl_next;
   logic [7:0] status_reg, status_next;

   function automatic logic gated(input logic [7:0] a);
      gated = (a >= CHGSV_CFG1_OFS && a <= CHGSV_CFG4_OFS) || a == CHGSV_NVCTRL_OFS;
   endfunction : gated

   // I2C slave state
   chgsv_i2c_t st_reg, st_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic [7:0] ptr_reg, ptr_next;
   logic       rw_reg, rw_next;
   logic       ptr_ok_reg, ptr_ok_next;
   logic       sda_oe_reg, sda_oe_next;
   logic       got_reg, got_next;
   logic       st_read;
   logic       wr_en;
   logic [7:0] rd_val;

   always_comb
   begin
      unique case (1'b1)
         ptr_reg == CHGSV_STATUS_OFS: rd_val = status_reg;
         gated(ptr_reg) && unlock_reg && ptr_reg != CHGSV_NVCTRL_OFS:
            rd_val = cfg_reg[2'(ptr_reg - CHGSV_CFG1_OFS)];
         ptr_reg == CHGSV_NVCTRL_OFS && unlock_reg: rd_val = nvctl_reg;
         ptr_reg == CHGSV_UNLOCK_OFS: rd_val = {7'h00, unlock_reg};
         default: rd_val = 8'h00;
      endcase
   end

   always_comb
   begin
      st_next     = st_reg;
      bit_next    = bit_reg;
      sh_next     = sh_reg;
      ptr_next    = ptr_reg;
      rw_next     = rw_reg;
      ptr_ok_next = ptr_ok_reg;
      sda_oe_next = sda_oe_reg;
      got_next    = got_reg;
      st_read     = 1'b0;
      wr_en       = 1'b0;
      if (start_c)
      begin
         st_next = CHGSV_I_ADDR;
         bit_next = 3'h0;
         got_next = 1'b0;
         sda_oe_next = 1'b0;
      end
      else if (stop_c)
      begin
         st_next = CHGSV_I_IDLE;
         sda_oe_next = 1'b0;
      end
      else
         unique case (st_reg)
            CHGSV_I_IDLE: sda_oe_next = 1'b0;
            CHGSV_I_ADDR, CHGSV_I_RX:
               if (scl_rise)
               begin
                  sh_next = {sh_reg[6:0], sda_s};
                  bit_next = bit_reg + 3'h1;
                  got_next = (bit_reg == 3'h7);
               end
               // Decide only once eight bits are in
               else if (scl_fall && got_reg)
               begin
                  got_next = 1'b0;
                  if (st_reg == CHGSV_I_ADDR)
                  begin
                     if (sh_reg[7:1] == {CHGSV_GROUP_ID, asel})
                     begin
                        rw_next = sh_reg[0];
                        ptr_ok_next = sh_reg[0] ? ptr_ok_reg : 1'b0;
                        sda_oe_next = 1'b1;
                        st_next = CHGSV_I_AACK;
                     end
                     else
                        st_next = CHGSV_I_IDLE;
                  end
                  else
                  begin
                     if (!ptr_ok_reg)
                     begin
                        ptr_next = sh_reg;
                        ptr_ok_next = 1'b1;
                     end
                     else
                     begin
                        wr_en = 1'b1;
                        ptr_next = ptr_reg + 8'h01;
                     end
                     sda_oe_next = 1'b1;
                     st_next = CHGSV_I_AACK;
                  end
               end
            CHGSV_I_AACK:
               if (scl_fall)
               begin
                  bit_next = 3'h0;
                  if (rw_reg)
                  begin
                     sh_next = rd_val;
                     st_read = (ptr_reg == CHGSV_STATUS_OFS);
                     ptr_next = ptr_reg + 8'h01;
                     sda_oe_next = ~rd_val[7];
                     st_next = CHGSV_I_TX;
                  end
                  else
                  begin
                     sda_oe_next = 1'b0;
                     st_next = CHGSV_I_RX;
                  end
               end
            CHGSV_I_TX:
               if (scl_fall)
               begin
                  bit_next = bit_reg + 3'h1;
                  sh_next = {sh_reg[6:0], 1'b0};
                  if (bit_reg == 3'h7)
                  begin
                     sda_oe_next = 1'b0;
                     st_next = CHGSV_I_DACK;
                  end
                  else
                     sda_oe_next = ~sh_reg[6];
               end
            CHGSV_I_DACK:
               if (scl_rise)
                  st_next = sda_s ? CHGSV_I_IDLE : CHGSV_I_AACK;
            default: st_next = CHGSV_I_IDLE;
         endcase
   end

   // Register writes and unlock gating
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         cfg_next[i] = cfg_reg[i];
      unlock_next = unlock_reg;
      nvctl_next = nvctl_reg;
      if (wr_en)
      begin
         if (ptr_reg == CHGSV_UNLOCK_OFS)
            unlock_next = sh_reg[0];
         else if (unlock_reg && ptr_reg == CHGSV_NVCTRL_OFS)
            nvctl_next = sh_reg;
         else if (unlock_reg && gated(ptr_reg))
            cfg_next[2'(ptr_reg - CHGSV_CFG1_OFS)] = sh_reg;
      end
   end

   // Temperature bands: zone bits = {<0,>10,>11,>44,>45,>60(cold side/hot side)}
   // therm_zone: [5]below0 [4]above10 [3]above11 [2]above44 [1]above45 [0]above60
   // with [5] and [0] from the hysteresis-qualified comparators
   logic [1:0] band_reg, band_next;
   logic       temp_bad_reg, temp_bad_next;
   always_comb
   begin
      band_next = band_reg;
      temp_bad_next = temp_bad_reg;
      if (sn.therm_zone[5] || sn.therm_zone[0])
         temp_bad_next = 1'b1;
      else if (!sn.therm_zone[4] == 1'b0 && !sn.therm_zone[2] == 1'b1 || band_reg != 2'h0)
         temp_bad_next = temp_bad_reg & (band_reg == 2'h0 ? 1'b0 : 1'b0);
      if (band_reg == 2'h0 && sn.therm_zone[3]) band_next = 2'h1;
      else if (band_reg == 2'h1 && !sn.therm_zone[4]) band_next = 2'h0;
      else if (band_reg == 2'h1 && sn.therm_zone[1]) band_next = 2'h2;
      else if (band_reg == 2'h2 && !sn.therm_zone[2]) band_next = 2'h1;
   end

   // Charge sequencer and status
   chgsv_state_t cs_reg, cs_next;
   logic run_reg, run_next;
   logic sw_oe_reg, sw_oe_next;
   logic flt_reg, flt_next;
   logic [7:0] ev;
   always_comb
   begin
      run_next = run_reg;
      if (!en_s || sn.supply_fall) run_next = 1'b0;
      else if (sn.supply_rise) run_next = 1'b1;
      ev = 8'h00;
      ev[CHGSV_BIT_OV]    = sn.batt_over;
      ev[CHGSV_BIT_FCTO]  = sn.full_charge_timeout;
      ev[CHGSV_BIT_COLD]  = sn.therm_zone[5] & temp_bad_next;
      ev[CHGSV_BIT_HOT]   = sn.therm_zone[0] & temp_bad_next;
      ev[CHGSV_BIT_TSD]   = ~sw_oe_reg;
      ev[CHGSV_BIT_TOPTO] = sn.topoff_timeout;
      ev[CHGSV_BIT_UV]    = ~run_next & en_s;
      ev[CHGSV_BIT_OPEN]  = sn.therm_open;
      // Set wins over the read-clear
      status_next = (st_read ? CHGSV_STATUS_RST : status_reg) | ev;
      flt_next = |(status_next & CHGSV_FAULT_MASK);
      sw_oe_next = sw_oe_reg;
      if (sn.junction_hot) sw_oe_next = 1'b0;
      else if (sn.junction_cool) sw_oe_next = 1'b1;
      cs_next = cs_reg;
      if (!run_reg || |ev || temp_bad_reg)
         cs_next = CHGSV_INIT;
      else
         unique case (cs_reg)
            CHGSV_INIT: cs_next = CHGSV_PRE;
            CHGSV_PRE: if (sn.batt_above_pre) cs_next = CHGSV_FULL;
            CHGSV_FULL: if (sn.in_cv) cs_next = CHGSV_CV;
            CHGSV_CV: if (sn.cur_below_topend) cs_next = CHGSV_DONE;
            CHGSV_DONE: if (!sn.in_cv) cs_next = CHGSV_PRE;
            default: cs_next = CHGSV_INIT;
         endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_b_in)
      if (!rst_b_in)
      begin
         st_reg <= CHGSV_I_IDLE;
         bit_reg <= 3'h0;
         sh_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         ptr_ok_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         got_reg <= 1'b0;
         for (int i = 0; i < 4; i++)
            cfg_reg[i] <= CHGSV_CFG_RST;
         unlock_reg <= 1'b0;
         nvctl_reg <= 8'h00;
         status_reg <= CHGSV_STATUS_RST;
         band_reg <= 2'h1;
         temp_bad_reg <= 1'b0;
         cs_reg <= CHGSV_INIT;
         run_reg <= 1'b0;
         sw_oe_reg <= 1'b1;
         flt_reg <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         ptr_ok_reg <= ptr_ok_next;
         sda_oe_reg <= sda_oe_next;
         got_reg <= got_next;
         cfg_reg <= cfg_next;
         unlock_reg <= unlock_next;
         nvctl_reg <= nvctl_next;
         status_reg <= status_next;
         band_reg <= band_next;
         temp_bad_reg <= temp_bad_next;
         cs_reg <= cs_next;
         run_reg <= run_next;
         sw_oe_reg <= sw_oe_next;
         flt_reg <= flt_next;
      end

   // Registered regulator outputs
   logic ce_reg, pre_reg, lim_reg, swoe_o_reg;
   logic [2:0] vt_reg;
   logic [3:0] ic_reg;
   logic [1:0] pc_reg;
   logic [7:0] c1, c2, c3, c4;
   assign {c1, c2, c3, c4} = {cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3]};
   always_ff @(posedge sys_clk_in or negedge rst_b_in)
      if (!rst_b_in)
      begin
         ce_reg <= 1'b0;
         pre_reg <= 1'b0;
         lim_reg <= 1'b0;
         swoe_o_reg <= 1'b0;
         vt_reg <= 3'h0;
         ic_reg <= 4'h0;
         pc_reg <= 2'h0;
      end
      else
      begin
         ce_reg <= run_reg & sn.cycle_current_limit;
         pre_reg <= (cs_reg == CHGSV_PRE);
         lim_reg <= (cs_reg == CHGSV_FULL) & sn.src_over_limit;
         swoe_o_reg <= sw_oe_reg & run_reg & (cs_reg != CHGSV_INIT) & (cs_reg != CHGSV_DONE);
         pc_reg <= c1[7:6];
         unique case (band_reg)
            2'h0: {vt_reg, ic_reg} <= {c1[5:3], c3[7:4]};
            2'h1: {vt_reg, ic_reg} <= {c1[2:0], c3[3:0]};
            2'h2: {vt_reg, ic_reg} <= {c2[5:3], c4[7:4]};
            default: {vt_reg, ic_reg} <= {c2[2:0], c4[3:0]};
         endcase
      end

   assign sda_out = 1'b0;
   assign sda_oe_out = sda_oe_reg;
   assign fault_out_n_out = 1'b0;
   assign fault_oe_out = flt_reg;
   assign switch_node_oe_out = swoe_o_reg;
   assign cycle_end_out = ce_reg;
   assign precharge_out = pre_reg;
   assign current_limit_sel_out = lim_reg;
   assign vterm_code_out = vt_reg;
   assign icharge_code_out = ic_reg;
   assign pre_code_out = pc_reg;

   chk_fault_pin: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      |(status_reg & CHGSV_FAULT_MASK) && !st_read |=> fault_oe_out)
      else $error("fault output not asserted");
   chk_status_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      st_read && ev == 8'h00 |=> status_reg == 8'h00)
      else $error("status not cleared by read");
   chk_warn_nopin: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      (status_reg & CHGSV_FAULT_MASK) == 8'h00 && (ev & CHGSV_FAULT_MASK) == 8'h00
         |=> !fault_oe_out)
      else $error("warning drove fault output");
   chk_init_fault: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      sn.batt_over |=> cs_reg == CHGSV_INIT)
      else $error("fault did not force initialize");
   chk_uvlo_off: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      !en_s |=> ##1 cs_reg == CHGSV_INIT)
      else $error("ran while disabled");
   chk_tsd_off: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      sn.junction_hot |=> ##1 !switch_node_oe_out)
      else $error("switch node not tri-stated");
   chk_lock_write: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      wr_en && !unlock_reg |=> $stable(nvctl_reg))
      else $error("locked register written");
   chk_ptr_incr: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
      wr_en |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("pointer not advanced");
endmodule : chgsv_top

/* tb/chgsv_i2c_master.sv */
/*
 I2C bus master model: drives SCL, pulls SDA low or releases it.
 Assumes the bench resolves SDA with a pull-up; SCL period 160 ns.
*/
`timescale 1ns/1ps
module chgsv_i2c_master (
   // Clock
   input  wire logic clk_in,
   // Bus
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   initial
   begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick

   task automatic start();
      sda_low_out = 1'b0;
      scl_out = 1'b1;
      tick(10);
      sda_low_out = 1'b1;
      tick(10);
      scl_out = 1'b0;
   endtask : start

   task automatic stop();
      tick(5);
      sda_low_out = 1'b1;
      tick(5);
      scl_out = 1'b1;
      tick(10);
      sda_low_out = 1'b0;
      tick(20);
   endtask : stop

   // Data set mid-low, held through the high phase
   task automatic bit_cyc(input logic b, output logic s);
      tick(5);
      sda_low_out = ~b;
      tick(5);
      scl_out = 1'b1;
      tick(5);
      s = sda_in;
      tick(5);
      scl_out = 1'b0;
   endtask : bit_cyc

   // Eight bits MSB first, then the ninth (acknowledge) bit
   task automatic xfer(input logic [7:0] tx, input logic mack,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_cyc(tx[i], rx[i]);
      bit_cyc(mack, ack);
   endtask : xfer
endmodule : chgsv_i2c_master

/* tb/testbench.sv */
/*
 Self-checking bench of the charger supervisor through its I2C port.
 Assumes chgsv_i2c_master as bus master and a pulled-up SDA wire.
*/
`timescale 1ns/1ps
module testbench
   import chgsv_pkg::*;
;
   localparam logic [2:0] ASEL = 3'h5;
   localparam logic [6:0] DEV  = {CHGSV_GROUP_ID, ASEL};
   logic         sys_clk, rst_b, enable, scl, m_low, sda_oe, sda_o;
   logic         fault_n, fault_oe, sw_oe, cyc_end, pre, ilim;
   logic [2:0]   vterm;
   logic [3:0]   ichg;
   logic [1:0]   pcode;
   chgsv_sense_t sense;
   int           fails, check_count;
   wire          sda = ~(m_low | (sda_oe & ~sda_o));

   chgsv_top i_dut (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .enable_in(enable),
      .addr_select_in(ASEL), .sense_in(sense), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .fault_out_n_out(fault_n),
      .fault_oe_out(fault_oe), .switch_node_oe_out(sw_oe), .cycle_end_out(cyc_end),
      .precharge_out(pre), .current_limit_sel_out(ilim), .vterm_code_out(vterm),
      .icharge_code_out(ichg), .pre_code_out(pcode));
   chgsv_i2c_master i_master (.clk_in(sys_clk), .sda_in(sda), .scl_out(scl),
      .sda_low_out(m_low));

   initial
      sys_clk = 1'b0;
   always #4 sys_clk = ~sys_clk;

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_clk(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_clk

   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic [7:0] r;
      logic       a;
      i_master.xfer(b, 1'b1, r, a);
      check({7'h0, a}, {7'h0, exp_ack});
   endtask : send

   task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d [4], input int n);
      i_master.start();
      send({DEV, 1'b0}, 1'b0);
      send(ptr, 1'b0);
      for (int i = 0; i < n; i++)
         send(d[i], 1'b0);
      i_master.stop();
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] e [4], input int n);
      logic [7:0] r;
      logic       a;
      i_master.start();
      send({DEV, 1'b0}, 1'b0);
      send(ptr, 1'b0);
      i_master.stop();
      i_master.start();
      send({DEV, 1'b1}, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         i_master.xfer(8'hff, i == n - 1, r, a);
         check(r, e[i]);
      end
      i_master.stop();
   endtask : reg_rd

   // Stimulus for cause k; status bit is 7-k
   task automatic set_cause(input int k, input logic on);
      case (k)
         0: sense.batt_over = on;
         1: sense.full_charge_timeout = on;
         2: sense.therm_zone = on ? 6'h20 : 6'h18;
         3: sense.therm_zone = on ? 6'h1f : 6'h18;
         4: {sense.junction_hot, sense.junction_cool} = {on, ~on};
         5: sense.topoff_timeout = on;
         6: {sense.supply_rise, sense.supply_fall} = {~on, on};
         default: sense.therm_open = on;
      endcase
   endtask : set_cause

   initial
   begin
      repeat (90000) @(posedge sys_clk);
      fails++;
      $display("Run cut short by watchdog");
      test_done();
   end

   initial
   begin
      rst_b = 1'b0;
      enable = 1'b0;
      sense = '0;
      sense.junction_cool = 1'b1;
      sense.therm_zone = 6'h18;
      wait_clk(16);
      rst_b = 1'b1;
      wait_clk(8);
      check({3'h0, sda_o, fault_n, fault_oe, sda_oe, sw_oe}, 8'h0);
      i_master.start();
      send({CHGSV_GROUP_ID, 3'h0, 1'b0}, 1'b1);
      i_master.stop();
      $display("test reset and address done");
      reg_wr(CHGSV_CFG1_OFS, '{8'hff, 8'h0, 8'h0, 8'h0}, 1);
      reg_rd(CHGSV_CFG1_OFS, '{8'h0, 8'h0, 8'h0, 8'h0}, 1);
      reg_wr(CHGSV_UNLOCK_OFS, '{8'h01, 8'h0, 8'h0, 8'h0}, 1);
      reg_rd(CHGSV_UNLOCK_OFS, '{8'h01, 8'h0, 8'h0, 8'h0}, 1);
      reg_wr(CHGSV_CFG1_OFS, '{8'h5d, 8'h00, 8'ha7, 8'h0}, 3);
      reg_rd(CHGSV_CFG1_OFS, '{8'h5d, 8'h00, 8'ha7, 8'h0}, 3);
      reg_wr(CHGSV_STATUS_OFS, '{8'hff, 8'h0, 8'h0, 8'h0}, 1);
      reg_rd(CHGSV_STATUS_OFS, '{8'h00, 8'h0, 8'h0, 8'h0}, 1);
      $display("test registers done");
      enable = 1'b1;
      sense.supply_rise = 1'b1;
      wait_clk(40);
      check({7'h0, sw_oe}, 8'h1);
      check({7'h0, pre}, 8'h1);
      check({pcode, vterm, 3'h0}, {2'h1, 3'h5, 3'h0});
      check({4'h0, ichg}, 8'h7);
      sense.therm_zone = 6'h00;
      wait_clk(40);
      check({ichg, 1'b0, vterm}, 8'ha3);
      sense.therm_zone = 6'h10;
      wait_clk(40);
      check({5'h0, vterm}, 8'h3);
      sense.therm_zone = 6'h18;
      wait_clk(40);
      check({5'h0, vterm}, 8'h5);
      sense.batt_above_pre = 1'b1;
      sense.src_over_limit = 1'b1;
      sense.cycle_current_limit = 1'b1;
      wait_clk(40);
      check({pre, ilim, cyc_end}, 8'h3);
      sense.in_cv = 1'b1;
      wait_clk(40);
      check({6'h0, ilim, sw_oe}, 8'h1);
      sense.cur_below_topend = 1'b1;
      wait_clk(40);
      check({7'h0, sw_oe}, 8'h0);
      {sense.in_cv, sense.cur_below_topend} = 2'b00;
      sense.src_over_limit = 1'b0;
      sense.cycle_current_limit = 1'b0;
      reg_rd(CHGSV_STATUS_OFS, '{8'h00, 8'h0, 8'h0, 8'h0}, 1);
      $display("test charge sequence done");
      for (int k = 0; k < 8; k++)
      begin
         set_cause(k, 1'b1);
         wait_clk(40);
         check({7'h0, fault_oe}, 8'(k < 4));
         if (k == 4)
            check({7'h0, sw_oe}, 8'h0);
         set_cause(k, 1'b0);
         wait_clk(40);
         check({7'h0, fault_oe}, 8'(k < 4));
         reg_rd(CHGSV_STATUS_OFS, '{8'(8'h80 >> k), 8'h0, 8'h0, 8'h0}, 1);
         wait_clk(40);
         check({7'h0, fault_oe}, 8'h0);
         reg_rd(CHGSV_STATUS_OFS, '{8'h00, 8'h0, 8'h0, 8'h0}, 1);
         $display("test cause %0d done", k);
      end
      test_done();
   end
endmodule : testbench
